// File: verilog/flash_self_program.sv
// Flash self-programming sequencer: control register, command windows, page buffer and busy tracking.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module flash_self_program #(
  parameter int PAGE_WORD_BITS = 6,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h1C00,
  parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_FIRST_WORD = 16'h1C00
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire spm_pkg::cpu_req_type cpu,
  input wire logic global_irq_enable,
  input wire logic eeprom_busy,
  input wire logic boot_vector_select_fuse,
  input wire spm_pkg::fuse_bank_type fuses,
  input wire logic flash_done,
  input wire logic [PAGE_WORD_BITS-1:0] buf_index,
  output logic [15:0] buf_data,
  output logic [15:0] reset_vector,
  output spm_pkg::flash_req_type flash_req,
  output logic cpu_halt,
  output logic rww_read_block,
  output logic lpm_special,
  output logic [7:0] lpm_data,
  output logic ready_irq
);

  localparam int WORDS = 1 << PAGE_WORD_BITS;

  // ==========================================================================
  // Reset release.
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync_ff;

  // ==========================================================================
  // Command decode.
  spm_pkg::seq_state_type state_ff;
  spm_pkg::op_type op_ff;
  logic [2:0] win_ff;
  logic irq_en_ff;
  logic busy_flag_ff;
  logic ctrl_write;
  logic legal_cmd;
  logic cmd_start;
  logic armed;
  logic store_hit;
  logic lpm_hit;
  logic timeout;
  logic buf_clear;
  logic op_to_rww;
  logic [15:0] page_ptr;
  logic [15:0] page_mask;
  logic [PAGE_WORD_BITS-1:0] word_sel;

  assign ctrl_write = reg_wr && (reg_addr == spm_pkg::CTRL_OFFSET);
  assign legal_cmd = (reg_wdata[4:0] == spm_pkg::CMD_RWWRE) || (reg_wdata[4:0] == spm_pkg::CMD_LOCK) ||
                     (reg_wdata[4:0] == spm_pkg::CMD_WRITE) || (reg_wdata[4:0] == spm_pkg::CMD_ERASE) ||
                     (reg_wdata[4:0] == spm_pkg::CMD_LOAD);
  // Commands are accepted only from idle, so a read-enable cannot act while erase or write runs.
  assign cmd_start = ctrl_write && legal_cmd && !eeprom_busy && (state_ff == spm_pkg::IDLE);
  assign armed = (state_ff == spm_pkg::ARMED);
  assign store_hit = armed && cpu.store && (win_ff < spm_pkg::STORE_WINDOW);
  assign lpm_hit = armed && (op_ff == spm_pkg::OP_LOCK) && cpu.load_prog && !cpu.store &&
                   !eeprom_busy && (win_ff < spm_pkg::LOAD_WINDOW);
  assign timeout = armed && !store_hit && !lpm_hit && (win_ff == spm_pkg::STORE_WINDOW - 3'h1);
  assign page_mask = ~16'((1 << (PAGE_WORD_BITS + 1)) - 1);
  assign page_ptr = cpu.ptr & page_mask;
  assign word_sel = cpu.ptr[PAGE_WORD_BITS:1];
  assign op_to_rww = page_ptr[15:1] < NO_READ_WHILE_WRITE_SECTION_FIRST_WORD[14:0];
  assign buf_clear = (cmd_start && (reg_wdata[4:0] == spm_pkg::CMD_RWWRE)) ||
                     (state_ff == spm_pkg::BUSY && flash_done && op_ff == spm_pkg::OP_WRITE);

  // ==========================================================================
  // Sequencer state and window counter.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= spm_pkg::IDLE;
      op_ff <= spm_pkg::OP_LOAD;
      win_ff <= 3'h0;
    end else begin
      unique case (state_ff)
        spm_pkg::IDLE: begin
          win_ff <= 3'h0;
          if (cmd_start) begin
            state_ff <= spm_pkg::ARMED;
            unique case (reg_wdata[4:0])
              spm_pkg::CMD_RWWRE: op_ff <= spm_pkg::OP_RWWRE;
              spm_pkg::CMD_LOCK: op_ff <= spm_pkg::OP_LOCK;
              spm_pkg::CMD_WRITE: op_ff <= spm_pkg::OP_WRITE;
              spm_pkg::CMD_ERASE: op_ff <= spm_pkg::OP_ERASE;
              default: op_ff <= spm_pkg::OP_LOAD;
            endcase
          end
        end
        spm_pkg::ARMED: begin
          win_ff <= win_ff + 3'h1;
          if (store_hit) begin
            if (op_ff == spm_pkg::OP_ERASE || op_ff == spm_pkg::OP_WRITE || op_ff == spm_pkg::OP_LOCK) begin
              state_ff <= spm_pkg::BUSY;
            end else begin
              state_ff <= spm_pkg::IDLE;
            end
          end else if (lpm_hit || timeout) begin
            state_ff <= spm_pkg::IDLE;
          end
        end
        spm_pkg::BUSY: begin
          if (flash_done) begin
            state_ff <= spm_pkg::IDLE;
          end
        end
        default: state_ff <= spm_pkg::IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt enable and ready request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_ff <= spm_pkg::CTRL_RESET[spm_pkg::IRQ_EN_BIT];
    end else if (ctrl_write) begin
      irq_en_ff <= reg_wdata[spm_pkg::IRQ_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= irq_en_ff && global_irq_enable && (state_ff == spm_pkg::IDLE);
    end
  end

  // ==========================================================================
  // Section busy flag, CPU halt and latched flash request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_flag_ff <= 1'b0;
    end else if (store_hit && (op_ff == spm_pkg::OP_ERASE || op_ff == spm_pkg::OP_WRITE) && op_to_rww) begin
      busy_flag_ff <= 1'b1;
    end else if (store_hit && (op_ff == spm_pkg::OP_LOAD || op_ff == spm_pkg::OP_RWWRE)) begin
      busy_flag_ff <= 1'b0;
    end
  end

  assign rww_read_block = busy_flag_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt <= 1'b0;
    end else if (store_hit && (op_ff == spm_pkg::OP_ERASE || op_ff == spm_pkg::OP_WRITE)) begin
      cpu_halt <= !op_to_rww;
    end else if (state_ff == spm_pkg::BUSY && flash_done) begin
      cpu_halt <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_req <= '0;
    end else begin
      flash_req.erase <= store_hit && (op_ff == spm_pkg::OP_ERASE);
      flash_req.write <= store_hit && (op_ff == spm_pkg::OP_WRITE);
      flash_req.lock_prog <= store_hit && (op_ff == spm_pkg::OP_LOCK);
      if (store_hit && (op_ff == spm_pkg::OP_ERASE || op_ff == spm_pkg::OP_WRITE)) begin
        flash_req.addr <= page_ptr;
      end
      if (store_hit && (op_ff == spm_pkg::OP_LOCK)) begin
        flash_req.lock_data <= cpu.data[7:0];
      end
    end
  end

  // ==========================================================================
  // Fuse and lock readback for program loads.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lpm_special <= 1'b0;
      lpm_data <= 8'h00;
    end else begin
      lpm_special <= lpm_hit;
      if (lpm_hit) begin
        unique case (cpu.ptr[1:0])
          2'h0: lpm_data <= fuses.fuse_low;
          2'h1: lpm_data <= fuses.lock;
          2'h2: lpm_data <= fuses.fuse_ext;
          default: lpm_data <= fuses.fuse_high;
        endcase
      end
    end
  end

  // ==========================================================================
  // Page buffer: random-order word loads, one write per word until cleared.
  logic [15:0] buf_mem [WORDS];
  logic [WORDS-1:0] buf_valid_ff;
  logic buf_load;

  assign buf_load = store_hit && (op_ff == spm_pkg::OP_LOAD);

  generate
    for (genvar i = 0; i < WORDS; i++) begin : g_word
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          buf_valid_ff[i] <= 1'b0;
        end else if (buf_clear) begin
          buf_valid_ff[i] <= 1'b0;
        end else if (buf_load && (word_sel == PAGE_WORD_BITS'(i))) begin
          buf_valid_ff[i] <= 1'b1;
        end
      end

      always_ff @(posedge clk) begin
        if (buf_load && !buf_valid_ff[i] && (word_sel == PAGE_WORD_BITS'(i))) begin
          buf_mem[i] <= cpu.data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_data <= spm_pkg::ERASED_WORD;
    end else begin
      buf_data <= buf_valid_ff[buf_index] ? buf_mem[buf_index] : spm_pkg::ERASED_WORD;
    end
  end

  // ==========================================================================
  // Reset vector; the fuse is only an input, so the processor cannot alter it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_vector <= spm_pkg::APP_RESET_ADDR;
    end else begin
      reset_vector <= boot_vector_select_fuse ? spm_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR;
    end
  end

  // ==========================================================================
  // Register read port.
  logic [7:0] ctrl_view;
  logic sen;

  assign sen = (state_ff != spm_pkg::IDLE);
  assign ctrl_view = {irq_en_ff, busy_flag_ff, 1'b0, sen && (op_ff == spm_pkg::OP_RWWRE),
                      sen && (op_ff == spm_pkg::OP_LOCK), sen && (op_ff == spm_pkg::OP_WRITE),
                      sen && (op_ff == spm_pkg::OP_ERASE), sen};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && (reg_addr == spm_pkg::CTRL_OFFSET)) begin
      reg_rdata <= ctrl_view;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: verilog/spm_pkg.sv
// Constants, types and carriers shared by the flash self-programming control logic.
// How it works
// - Unprogrammed boot fuse resets to address zero; programmed fuse resets to boot loader.
// - Processor has no path to change the boot vector select fuse.
// - Ready interrupt requests continuously while enabled, global flag set, store enable clear.
// - Busy flag sets when erase or write to read-while-write section starts; blocks reads.
// - Busy flag clears on completed read-enable command or on buffer load start.
// - Read-enable command re-enables section reads; ignored while erase or write runs.
// - Read-enable write during buffer loading aborts load and discards buffered data.
// - Lock-set store within four cycles programs boot lock bits from low data.
// - Program load within three cycles after lock set returns lock or fuse bits.
// - Page-write store within four cycles writes buffer to page named by pointer.
// - Page-erase store within four cycles erases page named by pointer upper bits.
// - Erase or write to no-read-while-write section halts the CPU throughout.
// - Erase or write to read-while-write section keeps other section fetches working.
// - Store enable alone makes next store load data pair into addressed buffer word.
// - Store enable clears after store or four idle cycles; held during erase/write (the code also holds it after a lock-set store until flash_done).
// - Only five low-five-bit patterns are commands; any other write starts no operation.
// - Sixteen-bit pointer: low bits pick word in page, high bits pick page.
// - Target address is latched when an operation starts; later pointer changes ignored.
// - Program loads use pointer bit zero as byte select.
// - Buffer words may be loaded in any order.
// - Page erase uses only the page field of the pointer.
// - Buffer clears after page write, read-enable command and system reset.
// - EEPROM write in progress blocks flash programming and fuse and lock reads.
package spm_pkg;

  // ==========================================================================
  // Register map and fields
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int IRQ_EN_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int RESERVED_BIT = 5;
  localparam logic [4:0] CMD_RWWRE = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;

  // ==========================================================================
  // Timing and reset values
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {IDLE, ARMED, BUSY} seq_state_type;
  typedef enum logic [2:0] {OP_LOAD, OP_ERASE, OP_WRITE, OP_RWWRE, OP_LOCK} op_type;

  typedef struct packed {
    logic store;
    logic load_prog;
    logic [15:0] ptr;
    logic [15:0] data;
  } cpu_req_type;

  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] fuse_ext;
  } fuse_bank_type;

  typedef struct packed {
    logic erase;
    logic write;
    logic lock_prog;
    logic [15:0] addr;
    logic [7:0] lock_data;
  } flash_req_type;

endpackage

// File: verif/spm_asserts.sv
// Concurrent checks on the ports of the flash self-programming control block.
`timescale 1ns/1ps
module spm_asserts #(
  parameter int PAGE_WORD_BITS = 6,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h1C00
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire spm_pkg::cpu_req_type cpu,
  input wire logic global_irq_enable,
  input wire logic eeprom_busy,
  input wire logic boot_vector_select_fuse,
  input wire logic flash_done,
  input wire logic [15:0] reset_vector,
  input wire spm_pkg::flash_req_type flash_req,
  input wire logic cpu_halt,
  input wire logic rww_read_block,
  input wire logic lpm_special,
  input wire logic ready_irq
);
  logic [2:0] up_ff;
  // ===========================================================================
  // Cycles since reset release, saturating once the reset vector has settled.
  always_ff @(posedge clk or negedge rst_b) begin
    up_ff <= !rst_b ? 3'h0 : up_ff + 3'(up_ff != 3'h4);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_vector_fuse: assert property (up_ff == 3'h4 && $stable(boot_vector_select_fuse) |->
    reset_vector == (boot_vector_select_fuse ? 16'h0000 : BOOT_RESET_ADDR)) else $error("reset vector mismatch");
  a_reserved_zero: assert property (reg_rd && reg_addr == 4'h0 |=> !reg_rdata[5])
    else $error("reserved bit reads one");
  a_erase_cause: assert property (flash_req.erase |-> $past(cpu.store))
    else $error("erase without store");
  a_write_cause: assert property (flash_req.write || flash_req.lock_prog |-> $past(cpu.store))
    else $error("write or lock without store");
  a_page_only: assert property (flash_req.erase || flash_req.write |-> flash_req.addr[PAGE_WORD_BITS:0] == '0)
    else $error("word bits leak into page address");
  a_halt_start: assert property ($rose(cpu_halt) |-> $past(cpu.store))
    else $error("halt without store");
  a_halt_end: assert property (flash_done |=> !cpu_halt)
    else $error("halt outlives completion");
  a_busy_set: assert property ($rose(rww_read_block) |-> !cpu_halt && ($past(cpu.store) || $past(cpu.store, 2)))
    else $error("busy flag set without store");
  a_busy_clear: assert property ($fell(rww_read_block) |-> $past(cpu.store) || $past(cpu.store, 2))
    else $error("busy flag cleared without store");
  a_fuse_read: assert property (lpm_special |-> $past(cpu.load_prog) && !$past(eeprom_busy))
    else $error("fuse read without load");
  a_irq_gate: assert property (!global_irq_enable [*2] |=> !ready_irq)
    else $error("interrupt without global enable");
  c_erase: cover property (flash_req.erase);
  c_halt_done: cover property (cpu_halt && flash_done);
  c_fuse_read: cover property (lpm_special);
endmodule

// File: verif/cpu_model.sv
// Processor core model issuing store and load program instructions.
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk,
  input wire logic [1:0] kind,
  input wire logic [15:0] ptr,
  input wire logic [15:0] data,
  output spm_pkg::cpu_req_type cpu
);
  // An idle core leaves pointer and data changing every cycle, never holding the last value.
  initial cpu = '0;
  always @(posedge clk) begin
    cpu.store <= kind == 2'h1;
    cpu.load_prog <= kind == 2'h2;
    cpu.ptr <= kind != 2'h0 ? ptr : ~cpu.ptr;
    cpu.data <= kind != 2'h0 ? data : ~cpu.data;
  end
endmodule

// File: verif/flash_self_program_tb.sv
// Self-checking bench for the flash self-programming control block.
`timescale 1ns/1ps
module flash_self_program_tb;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, flash_done = 1'b0;
  logic global_irq_enable = 1'b0, eeprom_busy = 1'b0, boot_vector_select_fuse = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, lpm_data;
  logic [1:0] kind = 2'h0;
  logic [15:0] ptr = 16'h0000, data = 16'h0000, da, db, buf_data, reset_vector;
  logic [5:0] buf_index = 6'h00, a;
  logic cpu_halt, rww_read_block, lpm_special, ready_irq;
  spm_pkg::fuse_bank_type fuses = '0;
  spm_pkg::cpu_req_type cpu;
  spm_pkg::flash_req_type flash_req;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  cpu_model cm (.*);
  flash_self_program dut (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= 4'h0;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  // ===========================================================================
  // Core instruction issued right after a control write, then the array's completion.
  task automatic op(input logic [1:0] k, input logic [15:0] p, input logic [15:0] d);
    kind <= k;
    ptr <= p;
    data <= d;
    @(posedge clk);
    kind <= 2'h0;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic fin;
    @(posedge clk);
    flash_done <= 1'b1;
    @(posedge clk);
    flash_done <= 1'b0;
  endtask
  task automatic ld(input logic [5:0] i, input logic [15:0] d);
    wr(8'h01);
    op(2'h1, {9'h000, i, 1'($urandom)}, d);
  endtask
  task automatic bchk(input logic [5:0] i, input logic [15:0] e);
    @(posedge clk);
    buf_index <= i;
    @(posedge clk);
    @(negedge clk);
    chk(buf_data, e);
  endtask
  task automatic prog(input logic [7:0] c, input logic [15:0] p, input logic n);
    wr(c);
    op(2'h1, p, 16'($urandom));
    chk({flash_req.erase, flash_req.write}, {c == 8'h03, c == 8'h05});
    chk(flash_req.addr, p & 16'hFF80);
    chk(cpu_halt, n);
    if (!n) begin
      wr(8'h11);
    end
    rd(4'h0, {1'b0, !n, 1'b0, c[4:0]});
    fin;
    rd(4'h0, {1'b0, !n, 6'h00});
    chk(cpu_halt, 1'b0);
  endtask
  function automatic logic [7:0] fsel(input logic [1:0] s);
    case (s)
      2'h0: return fuses.fuse_low;
      2'h1: return fuses.lock;
      2'h2: return fuses.fuse_ext;
      default: return fuses.fuse_high;
    endcase
  endfunction
  task automatic report_and_stop;
    $display("%0d comparisons, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(24));
    fuses = $urandom;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    chk(reset_vector, 16'h0000);
    rd(4'h0, 8'h00);
    wr(8'hFF);
    rd(4'h0, 8'h80);
    rd(4'h7, 8'h00);
    wr(8'h01);
    rd(4'h0, 8'h01);
    repeat (3) @(posedge clk);
    rd(4'h0, 8'h00);
    $display("test registers finished");
    a = 6'($urandom);
    da = 16'($urandom);
    db = 16'($urandom);
    ld(~a, db);
    ld(a, da);
    bchk(a, da);
    bchk(~a, db);
    $display("test page load finished");
    prog(8'h03, 16'($urandom) & 16'h1FFF, 1'b0);
    wr(8'h11);
    op(2'h1, 16'h0000, 16'h0000);
    rd(4'h0, 8'h00);
    bchk(a, 16'hFFFF);
    prog(8'h03, 16'h1234, 1'b0);
    ld(a, da);
    rd(4'h0, 8'h00);
    prog(8'h03, 16'h3880, 1'b1);
    prog(8'h05, 16'h3880, 1'b1);
    bchk(a, 16'hFFFF);
    $display("test programming finished");
    for (int i = 0; i < 4; i++) begin
      wr(8'h09);
      op(2'h2, 16'(i), 16'h0000);
      chk(lpm_special, 1'b1);
      chk(lpm_data, fsel(2'(i)));
    end
    wr(8'h09);
    op(2'h1, 16'h0001, da);
    chk({flash_req.lock_prog, flash_req.lock_data}, {1'b1, da[7:0]});
    fin;
    @(posedge clk);
    eeprom_busy <= 1'b1;
    wr(8'h09);
    rd(4'h0, 8'h00);
    @(posedge clk);
    eeprom_busy <= 1'b0;
    global_irq_enable <= 1'b1;
    wr(8'h80);
    repeat (3) @(negedge clk);
    chk(ready_irq, 1'b1);
    @(posedge clk);
    global_irq_enable <= 1'b0;
    repeat (3) @(negedge clk);
    chk(ready_irq, 1'b0);
    $display("test fuses, locks and interrupt finished");
    @(posedge clk);
    boot_vector_select_fuse <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    chk(reset_vector, 16'h1C00);
    $display("test boot vector finished");
    report_and_stop;
  end
endmodule
bind flash_self_program spm_asserts #(.PAGE_WORD_BITS(PAGE_WORD_BITS), .BOOT_RESET_ADDR(BOOT_RESET_ADDR)) chk_i (.*);
